// File: inc/lpmrt_pkg.sv
// Constants shared by the self refresh, refresh masking, mode register read
// and temperature status logic of the memory device.
// Assumes a single 200 MHz core clock on which the controller pins are sampled.
package lpmrt_pkg;
   // Clock rate
   localparam int unsigned CLK_PERIOD_PS = 5000;

   // Temperature status refresh: longest time, rounded down to cycles
   localparam int unsigned SENSOR_UPD_MS = 16;
   localparam int unsigned SENSOR_UPD_CYCLES =
      int'((64'(SENSOR_UPD_MS) * 64'd1000000000) / 64'(CLK_PERIOD_PS));

   // Self refresh exit interval: least time, rounded up to cycles
   localparam int unsigned SR_EXIT_NS = 140;
   localparam int unsigned SR_EXIT_CYCLES =
      (SR_EXIT_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

   // Internal refresh pacing while in self refresh
   localparam int unsigned SR_TICK_CYCLES = 64;

   // Read path
   localparam int unsigned READ_LATENCY_DEF = 3;
   localparam int unsigned BURST_BEATS = 4;

   // Array organisation
   localparam int unsigned NUM_BANKS = 8;
   localparam int unsigned NUM_SEGS = 8;
   localparam int unsigned DQ_WIDTH = 32;
   localparam int unsigned DQS_WIDTH = 4;
   localparam int unsigned TEMP_W = 3;

   // Command encodings on the rising edge bus bits
   localparam logic [3:0] CMD_MODE_REG_READ = 4'h8;
   localparam logic [3:0] CMD_MODE_REG_WRITE = 4'h0;
   localparam logic [2:0] CMD_SELF_REF = 3'h4;

   // Field positions on the command/address bus
   localparam int unsigned CA_RISE_ADDR_LSB = 4;
   localparam int unsigned CA_FALL_ADDR_LSB = 0;
   localparam int unsigned CA_FALL_DATA_LSB = 2;

   // Mode register addresses
   localparam logic [7:0] MA_TEMPERATURE_STATUS = 8'h04;
   localparam logic [7:0] MA_BANK_REFRESH_MASK = 8'h10;
   localparam logic [7:0] MA_SEGMENT_REFRESH_MASK = 8'h11;
   localparam logic [7:0] MA_CALIB_PATTERN_A = 8'h20;
   localparam logic [7:0] MA_CALIB_PATTERN_B = 8'h28;

   // Calibration patterns, bit n is beat n
   localparam logic [3:0] CALIB_PATTERN_A_BEATS = 4'h5;
   localparam logic [3:0] CALIB_PATTERN_B_BEATS = 4'hC;

   // Reset values
   localparam logic [7:0] BANK_MASK_RESET = 8'h00;
   localparam logic [7:0] SEG_MASK_RESET = 8'h00;
   localparam logic [2:0] TEMP_STATUS_RESET = 3'h0;

   // Power state of the device
   typedef enum logic [1:0] {
      PWR_IDLE,
      PWR_SELF_REF,
      PWR_EXIT_WAIT
   } lpmrt_pwr_e;
endpackage : lpmrt_pkg

// File: logic/lpmrt_mask.sv
// Refresh region map: which bank and segment pairs stay refreshed.
// Assumes mask bits of one mean masked; purely combinational.
`timescale 1ns/1ps
module lpmrt_mask #(
   parameter int unsigned NUM_BANKS = lpmrt_pkg::NUM_BANKS,
   parameter int unsigned NUM_SEGS = lpmrt_pkg::NUM_SEGS
) (
   input wire logic [NUM_BANKS-1:0] bank_mask_i,
   input wire logic [NUM_SEGS-1:0] seg_mask_i,
   output logic [NUM_BANKS*NUM_SEGS-1:0] region_en_o
);
   import lpmrt_pkg::*;

   // One enable per region; index is bank * segments + segment
   for (genvar b = 0; b < NUM_BANKS; b++) begin : g_bank
      for (genvar s = 0; s < NUM_SEGS; s++) begin : g_seg
         // Same segment bit applies in every bank; both must be unmasked
         assign region_en_o[b*NUM_SEGS+s] = ~bank_mask_i[b] & ~seg_mask_i[s];
      end
   end
endmodule : lpmrt_mask

// File: logic/lpmrt_top.sv
// Device-side self refresh, partial array refresh masking, mode register
// read path, temperature status and calibration pattern readout.
// Assumes the controller drives cke, chip select and the command/address
// bus synchronously to clk_i; the temperature code arrives asynchronously.
`timescale 1ns/1ps
module lpmrt_top #(
   parameter int unsigned READ_LATENCY = lpmrt_pkg::READ_LATENCY_DEF,
   parameter int unsigned SR_EXIT_CYCLES = lpmrt_pkg::SR_EXIT_CYCLES,
   parameter int unsigned SR_TICK_CYCLES = lpmrt_pkg::SR_TICK_CYCLES,
   parameter int unsigned SENSOR_UPD_CYCLES = lpmrt_pkg::SENSOR_UPD_CYCLES
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic cke_i,
   input wire logic cs_n_i,
   input wire logic [9:0] ca_rise_i,
   input wire logic [9:0] ca_fall_i,
   input wire logic [lpmrt_pkg::TEMP_W-1:0] temp_sense_i,
   output logic [lpmrt_pkg::DQ_WIDTH-1:0] dq_o,
   output logic dq_oe_n_o,
   output logic [lpmrt_pkg::DQS_WIDTH-1:0] dqs_o,
   output logic dqs_oe_n_o,
   output logic cmd_ready_o,
   output logic self_refresh_o,
   output logic refresh_o,
   output logic [2:0] refresh_bank_o,
   output logic [2:0] refresh_seg_o
);
   import lpmrt_pkg::*;

   localparam int RL_D = int'(READ_LATENCY);
   localparam int EXIT_D = int'(SR_EXIT_CYCLES);
   localparam int RL_P1 = RL_D + 1;

   lpmrt_pwr_e pwr, next_pwr;
   logic cke_q, next_cke_q;
   logic [15:0] exit_cnt, next_exit_cnt;
   logic [7:0] bank_mask, next_bank_mask;
   logic [7:0] seg_mask, next_seg_mask;
   logic [TEMP_W-1:0] temp_sync1, temp_sync2, temp_status, next_temp_status;
   logic [31:0] upd_cnt, next_upd_cnt;
   logic rd_pend, next_rd_pend;
   logic rd_burst, next_rd_burst;
   logic [3:0] rd_wait, next_rd_wait;
   logic [1:0] rd_beat, next_rd_beat;
   logic [7:0] rd_word, next_rd_word;
   logic [3:0] rd_pat, next_rd_pat;
   logic rd_cal, next_rd_cal;
   logic [DQ_WIDTH-1:0] next_dq;
   logic next_oe_n;
   logic [DQS_WIDTH-1:0] next_dqs;
   logic [15:0] tick_cnt, next_tick_cnt;
   logic [5:0] region_ptr, next_region_ptr;
   logic next_refresh;
   logic [2:0] next_ref_bank, next_ref_seg;
   logic [NUM_BANKS*NUM_SEGS-1:0] region_en;
   logic [7:0] cmd_addr;
   logic cmd_live, is_read, is_write, is_sref, rd_accept, exit_event;

   // Command decode; only the idle state takes valid commands
   assign cmd_live = (pwr == PWR_IDLE) && cke_q && !cs_n_i;
   assign cmd_addr = {ca_fall_i[CA_FALL_ADDR_LSB +: 2], ca_rise_i[CA_RISE_ADDR_LSB +: 6]};
   assign is_read = cmd_live && cke_i && (ca_rise_i[3:0] == CMD_MODE_REG_READ);
   assign is_write = cmd_live && cke_i && (ca_rise_i[3:0] == CMD_MODE_REG_WRITE);
   // Entry refused while a read burst is still on the wires
   assign is_sref = cmd_live && !cke_i && (ca_rise_i[2:0] == CMD_SELF_REF) &&
                    !rd_pend && !rd_burst;
   // A read that lands on a busy read path is dropped so the burst stays whole
   assign rd_accept = is_read && !rd_pend && !rd_burst;
   assign exit_event = (pwr == PWR_SELF_REF) && cke_i;

   assign cmd_ready_o = (pwr == PWR_IDLE);
   assign self_refresh_o = (pwr == PWR_SELF_REF);

   // Power state: entry, self refresh and the exit interval
   always_comb begin
      next_pwr = pwr;
      next_exit_cnt = exit_cnt;
      next_cke_q = cke_i;
      unique case (pwr)
         PWR_IDLE: begin
            if (is_sref) begin
               next_pwr = PWR_SELF_REF;
            end
         end
         PWR_SELF_REF: begin
            // Interval starts on the edge that sees cke high
            if (cke_i) begin
               next_pwr = PWR_EXIT_WAIT;
               next_exit_cnt = 16'(SR_EXIT_CYCLES - 1);
            end
         end
         PWR_EXIT_WAIT: begin
            // Commands are ignored until the count runs out
            if (exit_cnt == 16'h0000) begin
               next_pwr = PWR_IDLE;
            end else begin
               next_exit_cnt = exit_cnt - 16'h0001;
            end
         end
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pwr <= PWR_IDLE;
         exit_cnt <= 16'h0000;
         cke_q <= 1'b0;
      end else begin
         pwr <= next_pwr;
         exit_cnt <= next_exit_cnt;
         cke_q <= next_cke_q;
      end
   end

   // Refresh masks; write-only, so reads of them return zero
   always_comb begin
      next_bank_mask = bank_mask;
      next_seg_mask = seg_mask;
      if (is_write && cmd_addr == MA_BANK_REFRESH_MASK) begin
         next_bank_mask = ca_fall_i[CA_FALL_DATA_LSB +: 8];
      end
      if (is_write && cmd_addr == MA_SEGMENT_REFRESH_MASK) begin
         next_seg_mask = ca_fall_i[CA_FALL_DATA_LSB +: 8];
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         bank_mask <= BANK_MASK_RESET;
         seg_mask <= SEG_MASK_RESET;
      end else begin
         bank_mask <= next_bank_mask;
         seg_mask <= next_seg_mask;
      end
   end

   // Temperature status: periodic update plus a forced one on exit
   always_comb begin
      next_temp_status = temp_status;
      next_upd_cnt = upd_cnt + 32'h0000_0001;
      if (exit_event || upd_cnt >= 32'(SENSOR_UPD_CYCLES - 1)) begin
         next_temp_status = temp_sync2;
         next_upd_cnt = 32'h0000_0000;
      end
   end

   // The first sync stage feeds only the second
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         temp_sync1 <= TEMP_STATUS_RESET;
         temp_sync2 <= TEMP_STATUS_RESET;
         temp_status <= TEMP_STATUS_RESET;
         upd_cnt <= 32'h0000_0000;
      end else begin
         temp_sync1 <= temp_sense_i;
         temp_sync2 <= temp_sync1;
         temp_status <= next_temp_status;
         upd_cnt <= next_upd_cnt;
      end
   end

   // Data of one beat: pattern on every line, or register byte on beat 0
   function automatic logic [DQ_WIDTH-1:0] beat_data(input logic cal, input logic [3:0] pat,
                                                     input logic [7:0] word,
                                                     input logic [1:0] beat);
      logic [DQ_WIDTH-1:0] d;
      d = '0;
      if (cal) begin
         d = {DQ_WIDTH{pat[beat]}};
      end else if (beat == 2'h0) begin
         d = {{(DQ_WIDTH-8){1'b0}}, word};
      end
      return d;
   endfunction : beat_data

   // Read path: latency wait, then four beats with toggling strobes
   always_comb begin
      next_rd_pend = rd_pend;
      next_rd_burst = rd_burst;
      next_rd_wait = rd_wait;
      next_rd_beat = rd_beat;
      next_rd_word = rd_word;
      next_rd_pat = rd_pat;
      next_rd_cal = rd_cal;
      next_dq = '0;
      next_oe_n = 1'b1;
      if (rd_accept) begin
         // Register contents are captured at the command edge
         next_rd_pend = 1'b1;
         next_rd_wait = 4'(READ_LATENCY - 1);
         next_rd_cal = (cmd_addr == MA_CALIB_PATTERN_A) || (cmd_addr == MA_CALIB_PATTERN_B);
         next_rd_pat = (cmd_addr == MA_CALIB_PATTERN_A) ? CALIB_PATTERN_A_BEATS :
                       CALIB_PATTERN_B_BEATS;
         next_rd_word = (cmd_addr == MA_TEMPERATURE_STATUS) ?
                        {{(8-TEMP_W){1'b0}}, temp_status} : 8'h00;
      end else if (rd_pend) begin
         if (rd_wait == 4'h0) begin
            next_rd_pend = 1'b0;
            next_rd_burst = 1'b1;
            next_rd_beat = 2'h0;
            next_dq = beat_data(rd_cal, rd_pat, rd_word, 2'h0);
            next_oe_n = 1'b0;
         end else begin
            next_rd_wait = rd_wait - 4'h1;
         end
      end else if (rd_burst) begin
         if (rd_beat == 2'(BURST_BEATS - 1)) begin
            next_rd_burst = 1'b0;
         end else begin
            next_rd_beat = rd_beat + 2'h1;
            next_dq = beat_data(rd_cal, rd_pat, rd_word, rd_beat + 2'h1);
            next_oe_n = 1'b0;
         end
      end
      // Strobe high on even beats, low on odd ones, on every lane
      next_dqs = next_oe_n ? '0 : {DQS_WIDTH{~next_rd_beat[0]}};
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rd_pend <= 1'b0;
         rd_burst <= 1'b0;
         rd_wait <= 4'h0;
         rd_beat <= 2'h0;
         rd_word <= 8'h00;
         rd_pat <= 4'h0;
         rd_cal <= 1'b0;
         dq_o <= '0;
         dq_oe_n_o <= 1'b1;
         dqs_o <= '0;
         dqs_oe_n_o <= 1'b1;
      end else begin
         rd_pend <= next_rd_pend;
         rd_burst <= next_rd_burst;
         rd_wait <= next_rd_wait;
         rd_beat <= next_rd_beat;
         rd_word <= next_rd_word;
         rd_pat <= next_rd_pat;
         rd_cal <= next_rd_cal;
         dq_o <= next_dq;
         dq_oe_n_o <= next_oe_n;
         dqs_o <= next_dqs;
         dqs_oe_n_o <= next_oe_n;
      end
   end

   lpmrt_mask #(
      .NUM_BANKS(NUM_BANKS),
      .NUM_SEGS(NUM_SEGS)
   ) u_mask (
      .bank_mask_i(bank_mask),
      .seg_mask_i(seg_mask),
      .region_en_o(region_en)
   );

   // Self refresh walker: visits every region, pulses only unmasked ones
   always_comb begin
      next_tick_cnt = 16'h0000;
      next_region_ptr = region_ptr;
      next_refresh = 1'b0;
      next_ref_bank = refresh_bank_o;
      next_ref_seg = refresh_seg_o;
      // No pulse on the exit edge, so a refresh never lands outside self refresh
      if (pwr == PWR_SELF_REF && !cke_i) begin
         next_tick_cnt = tick_cnt + 16'h0001;
         if (tick_cnt >= 16'(SR_TICK_CYCLES - 1)) begin
            next_tick_cnt = 16'h0000;
            next_region_ptr = region_ptr + 6'h01;
            next_refresh = region_en[region_ptr];
            next_ref_bank = region_ptr[5:3];
            next_ref_seg = region_ptr[2:0];
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tick_cnt <= 16'h0000;
         region_ptr <= 6'h00;
         refresh_o <= 1'b0;
         refresh_bank_o <= 3'h0;
         refresh_seg_o <= 3'h0;
      end else begin
         tick_cnt <= next_tick_cnt;
         region_ptr <= next_region_ptr;
         refresh_o <= next_refresh;
         refresh_bank_o <= next_ref_bank;
         refresh_seg_o <= next_ref_seg;
      end
   end

   // Checks on the read path, masks, exit interval and status age
   sequence s_pat_a;
      dq_o == 32'hFFFF_FFFF ##1 dq_o == 32'h0000_0000 ##1 dq_o == 32'hFFFF_FFFF
      ##1 dq_o == 32'h0000_0000;
   endsequence
   sequence s_pat_b;
      dq_o == 32'h0000_0000 ##1 dq_o == 32'h0000_0000 ##1 dq_o == 32'hFFFF_FFFF
      ##1 dq_o == 32'hFFFF_FFFF;
   endsequence
   sequence s_four_beats;
      (!dq_oe_n_o && !dqs_oe_n_o) [*4] ##1 dq_oe_n_o;
   endsequence

   property p_read_latency;
      @(posedge clk_i) disable iff (rst_i) rd_accept |=> ##RL_D s_four_beats;
   endproperty
   a_read_latency: assert property (p_read_latency) else $error("read burst late or short");
   // Lines stay released for the whole latency wait
   property p_wait_quiet;
      @(posedge clk_i) disable iff (rst_i) rd_pend |-> dq_oe_n_o && dqs_oe_n_o;
   endproperty
   a_wait_quiet: assert property (p_wait_quiet) else $error("data driven during latency");
   property p_strobe_toggle;
      @(posedge clk_i) disable iff (rst_i)
         $fell(dq_oe_n_o) |-> dqs_o == 4'hF ##1 dqs_o == 4'h0 ##1 dqs_o == 4'hF ##1 dqs_o == 4'h0;
   endproperty
   a_strobe_toggle: assert property (p_strobe_toggle) else $error("strobes not toggling");
   property p_cal_a;
      @(posedge clk_i) disable iff (rst_i)
         (rd_accept && cmd_addr == MA_CALIB_PATTERN_A) |=> ##RL_D s_pat_a;
   endproperty
   a_cal_a: assert property (p_cal_a) else $error("pattern A wrong");
   property p_cal_b;
      @(posedge clk_i) disable iff (rst_i)
         (rd_accept && cmd_addr == MA_CALIB_PATTERN_B) |=> ##RL_D s_pat_b;
   endproperty
   a_cal_b: assert property (p_cal_b) else $error("pattern B wrong");
   property p_temp_byte;
      @(posedge clk_i) disable iff (rst_i)
         (rd_accept && cmd_addr == MA_TEMPERATURE_STATUS) |=>
         ##RL_D dq_o == {29'h0000_0000, $past(temp_status, RL_P1)};
   endproperty
   a_temp_byte: assert property (p_temp_byte) else $error("status byte wrong");
   property p_exit_wait;
      @(posedge clk_i) disable iff (rst_i)
         exit_event |=> !cmd_ready_o [*1] ##[0:EXIT_D] cmd_ready_o;
   endproperty
   a_exit_wait: assert property (p_exit_wait) else $error("exit interval wrong");
   // Cycles since the exit edge, so the whole interval is checked, not only its end
   logic [15:0] exit_age, next_exit_age;
   always_comb begin
      next_exit_age = 16'h0000;
      if (exit_event) begin
         next_exit_age = 16'h0001;
      end else if (exit_age != 16'h0000 && exit_age <= 16'(SR_EXIT_CYCLES)) begin
         next_exit_age = exit_age + 16'h0001;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         exit_age <= 16'h0000;
      end else begin
         exit_age <= next_exit_age;
      end
   end

   property p_exit_min;
      @(posedge clk_i) disable iff (rst_i)
         exit_age != 16'h0000 |-> cmd_ready_o == (exit_age > 16'(SR_EXIT_CYCLES));
   endproperty
   a_exit_min: assert property (p_exit_min) else $error("exit interval not held");
   property p_bank_masked;
      @(posedge clk_i) disable iff (rst_i) refresh_o |-> !bank_mask[refresh_bank_o];
   endproperty
   a_bank_masked: assert property (p_bank_masked) else $error("masked bank refreshed");
   property p_seg_masked;
      @(posedge clk_i) disable iff (rst_i) refresh_o |-> !seg_mask[refresh_seg_o] && self_refresh_o;
   endproperty
   a_seg_masked: assert property (p_seg_masked) else $error("masked segment refreshed");
   property p_mask_write;
      @(posedge clk_i) disable iff (rst_i)
         (is_write && cmd_addr == MA_BANK_REFRESH_MASK) |=> bank_mask == $past(ca_fall_i[9:2]);
   endproperty
   a_mask_write: assert property (p_mask_write) else $error("bank mask not stored");
   property p_status_age;
      @(posedge clk_i) disable iff (rst_i) upd_cnt < 32'(SENSOR_UPD_CYCLES);
   endproperty
   a_status_age: assert property (p_status_age) else $error("status update overdue");
   property p_exit_fresh;
      @(posedge clk_i) disable iff (rst_i) exit_event |=> temp_status == $past(temp_sync2);
   endproperty
   a_exit_fresh: assert property (p_exit_fresh) else $error("status stale on exit");
endmodule : lpmrt_top

// File: dv/lpmrt_ctrl_model.sv
// Controller model driving clock enable, chip select and the command/address bus.
// Assumes the bench calls one task at a time, all on the shared core clock.
`timescale 1ns/1ps
module lpmrt_ctrl_model (
   input wire logic clk_i,
   output logic cke_o,
   output logic cs_n_o,
   output logic [9:0] ca_rise_o,
   output logic [9:0] ca_fall_o
);
   import lpmrt_pkg::*;

   // Idle bus at time zero: clock enabled, device deselected
   initial begin
      cke_o = 1'b1;
      cs_n_o = 1'b1;
      ca_rise_o = 10'h000;
      ca_fall_o = 10'h3FF;
   end

   // Deselect cycles; address lines keep moving so no stale value looks valid
   task automatic nop(input int n);
      repeat (n) begin
         @(posedge clk_i);
         cs_n_o <= 1'b1;
         ca_rise_o <= 10'($urandom);
         ca_fall_o <= 10'($urandom);
      end
   endtask : nop

   // One selected cycle, released right after the edge that takes it
   task automatic issue(input logic ck, input logic [9:0] rise, input logic [9:0] fall);
      @(posedge clk_i);
      cke_o <= ck;
      cs_n_o <= 1'b0;
      ca_rise_o <= rise;
      ca_fall_o <= fall;
      nop(1);
   endtask : issue

   // Register read; the caller stays quiet for the command period
   task automatic mode_register_read_cmd(input logic [7:0] a);
      issue(1'b1, {a[5:0], CMD_MODE_REG_READ}, {8'($urandom), a[7:6]});
   endtask : mode_register_read_cmd

   // Register write with quiet cycles after it, so nothing follows too closely
   task automatic mode_register_write_cmd(input logic [7:0] a, input logic [7:0] d);
      issue(1'b1, {a[5:0], CMD_MODE_REG_WRITE}, {d, a[7:6]});
      nop(4);
   endtask : mode_register_write_cmd

   // No bank is ever opened and no data burst is modelled, so entry is from idle
   task automatic sr_enter();
      issue(1'b0, {7'($urandom), CMD_SELF_REF}, 10'($urandom));
   endtask : sr_enter

   // Two stable clocks, then clock enable high with the device deselected
   task automatic sr_exit();
      nop(2);
      @(posedge clk_i);
      cke_o <= 1'b1;
   endtask : sr_exit
endmodule : lpmrt_ctrl_model

// File: dv/lpmrt_top_tb.sv
// Self-checking bench for refresh masking, register reads and temperature status.
// Assumes the controller model drives the command pins; counts are shortened.
`timescale 1ns/1ps
module lpmrt_top_tb;
   import lpmrt_pkg::*;
   localparam int unsigned RL = 3;
   localparam int unsigned XS = 6;
   localparam int unsigned TK = 4;
   localparam int unsigned TS = 50;
   localparam logic [7:0] CORNER [6] = '{MA_CALIB_PATTERN_A, MA_CALIB_PATTERN_B,
      MA_BANK_REFRESH_MASK, MA_SEGMENT_REFRESH_MASK, 8'h44, 8'hC4};
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic [TEMP_W-1:0] temp_sense = 3'h0;
   logic cke;
   logic cs_n;
   logic [9:0] ca_rise;
   logic [9:0] ca_fall;
   logic [DQ_WIDTH-1:0] dq;
   logic dq_oe_n;
   logic [DQS_WIDTH-1:0] dqs;
   logic dqs_oe_n;
   logic cmd_ready;
   logic self_refresh;
   logic refresh;
   logic [2:0] refresh_bank;
   logic [2:0] refresh_seg;
   logic [7:0] bmask = 8'h00;
   logic [7:0] smask = 8'h00;
   logic [TEMP_W-1:0] temp_val = 3'h0;
   logic [63:0] seen_map = 64'h0;
   logic [7:0] ra;
   int errors = 0;
   int n_compared = 0;

   // Core clock, 5 ns period
   always #2.5 clk_i = ~clk_i;

   lpmrt_top #(.READ_LATENCY(RL), .SR_EXIT_CYCLES(XS), .SR_TICK_CYCLES(TK),
      .SENSOR_UPD_CYCLES(TS)) DUT (
      .clk_i(clk_i), .rst_i(rst_i), .cke_i(cke), .cs_n_i(cs_n),
      .ca_rise_i(ca_rise), .ca_fall_i(ca_fall), .temp_sense_i(temp_sense),
      .dq_o(dq), .dq_oe_n_o(dq_oe_n), .dqs_o(dqs), .dqs_oe_n_o(dqs_oe_n),
      .cmd_ready_o(cmd_ready), .self_refresh_o(self_refresh), .refresh_o(refresh),
      .refresh_bank_o(refresh_bank), .refresh_seg_o(refresh_seg));

   lpmrt_ctrl_model ctrl (.clk_i(clk_i), .cke_o(cke), .cs_n_o(cs_n),
      .ca_rise_o(ca_rise), .ca_fall_o(ca_fall));

   task automatic check(input logic [63:0] got, input logic [63:0] exp);
      n_compared++;
      if (got !== exp) begin
         errors++;
         $display("wrong value at %0t: got %0h, expected %0h", $time, got, exp);
      end
   endtask : check

   task automatic print_verdict();
      if (errors == 0 && n_compared > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : print_verdict

   // Expected data lines of one read beat
   function automatic logic [31:0] exp_beat(input logic [7:0] a, input int b);
      case (a)
         MA_CALIB_PATTERN_A: return (b % 2 == 0) ? 32'hFFFF_FFFF : 32'h0000_0000;
         MA_CALIB_PATTERN_B: return (b >= 2) ? 32'hFFFF_FFFF : 32'h0000_0000;
         MA_TEMPERATURE_STATUS: return (b == 0) ? 32'(temp_val) : 32'h0000_0000;
         default: return 32'h0000_0000;
      endcase
   endfunction : exp_beat

   // Regions that should see refresh, index bank*8+segment
   function automatic logic [63:0] exp_map(input logic [7:0] bm, input logic [7:0] sm);
      logic [63:0] m;
      for (int i = 0; i < 64; i++) begin
         m[i] = !bm[i / 8] && !sm[i % 8];
      end
      return m;
   endfunction : exp_map

   // Read and check the whole burst; optionally try a second read mid-burst
   task automatic read_chk(input logic [7:0] a, input bit intrude);
      ctrl.mode_register_read_cmd(a);
      repeat (RL) @(posedge clk_i);
      for (int b = 0; b < 4; b++) begin
         if (b > 0) begin
            @(posedge clk_i);
         end
         #1;
         check(64'({dq_oe_n, dqs_oe_n}), 64'h0);
         check(64'(dqs), (b % 2 == 0) ? 64'hF : 64'h0);
         check(64'(dq), 64'(exp_beat(a, b)));
         if (intrude && b == 0) begin
            fork
               ctrl.mode_register_read_cmd(MA_CALIB_PATTERN_B);
            join_none
         end
      end
      repeat (intrude ? RL + 4 : 1) begin
         @(posedge clk_i);
         #1;
         check(64'({dq_oe_n, dq}), 64'h1_0000_0000);
      end
   endtask : read_chk

   // Self refresh sweep with given masks, then exit timing and fresh status
   task automatic sr_run(input logic [7:0] bm, input logic [7:0] sm, input bit wr);
      if (wr) begin
         ctrl.mode_register_write_cmd(MA_BANK_REFRESH_MASK, bm);
         ctrl.mode_register_write_cmd(MA_SEGMENT_REFRESH_MASK, sm);
      end
      bmask = bm;
      smask = sm;
      seen_map = 64'h0;
      ctrl.sr_enter();
      #1;
      check(64'({self_refresh, cmd_ready}), 64'h2);
      repeat (300) @(posedge clk_i);
      temp_val = temp_val + 3'(1 + $urandom % 7);
      temp_sense <= temp_val;
      repeat (4) @(posedge clk_i);
      ctrl.sr_exit();
      for (int k = 1; k <= XS + 1; k++) begin
         @(posedge clk_i);
         #1;
         check(64'(cmd_ready), 64'(k == XS + 1));
      end
      check(seen_map, exp_map(bm, sm));
      read_chk(MA_TEMPERATURE_STATUS, 1'b0);
   endtask : sr_run

   // Every internal refresh must land in a region left unmasked
   always @(posedge clk_i) begin
      if (!rst_i && refresh === 1'b1) begin
         check(64'(bmask[refresh_bank] | smask[refresh_seg]), 64'h0);
         seen_map[{refresh_bank, refresh_seg}] = 1'b1;
      end
   end

   // Main sequence
   initial begin
      void'($urandom(214));
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      #1;
      check(64'({cmd_ready, self_refresh, dq_oe_n, dqs_oe_n}), 64'hB);
      // Reset masks first: every region should refresh
      sr_run(8'h00, 8'h00, 1'b0);
      sr_run(8'h82, 8'h84, 1'b1);
      sr_run(8'hFF, 8'h00, 1'b1);
      sr_run(8'($urandom), 8'($urandom), 1'b1);
      // Calibration, write-only and aliasing addresses, all from idle
      for (int i = 0; i < 6; i++) begin
         read_chk(CORNER[i], 1'b0);
      end
      // A write to the status register must not change what it reports
      ctrl.mode_register_write_cmd(MA_TEMPERATURE_STATUS, ~8'(temp_val));
      read_chk(MA_TEMPERATURE_STATUS, 1'b0);
      read_chk(MA_CALIB_PATTERN_A, 1'b1);
      // Status follows the sensor within one update period
      @(posedge clk_i);
      temp_val = temp_val + 3'(1 + $urandom % 7);
      temp_sense <= temp_val;
      repeat (TS + 8) @(posedge clk_i);
      read_chk(MA_TEMPERATURE_STATUS, 1'b0);
      // Random mix of reads, each issued after the previous burst has ended
      repeat (12) begin
         case ($urandom % 4)
            0: ra = MA_CALIB_PATTERN_B;
            1: ra = MA_TEMPERATURE_STATUS;
            2: ra = MA_CALIB_PATTERN_A;
            default: ra = 8'($urandom);
         endcase
         read_chk(ra, 1'b0);
      end
      print_verdict();
   end

   // Watchdog: the sequence needs about 1,600 cycles
   initial begin
      repeat (10000) @(posedge clk_i);
      errors++;
      print_verdict();
   end
endmodule : lpmrt_top_tb
